// ===== hdl/ebsr_params.svh
// offsets, field positions and reset values for the special register bank
`ifndef EBSR_PARAMS_SVH
`define EBSR_PARAMS_SVH
`define EBSR_OFS_EVENT_SC 6'h39
`define EBSR_OFS_SHADOW 6'h3a
`define EBSR_OFS_BRANCH 6'h3b
`define EBSR_OFS_SCHED_CFG 6'h3c
`define EBSR_OFS_SCHED_ADDR 6'h3d
`define EBSR_EV_CMD_BIT 7
`define EBSR_EV_IDX_HI 3
`define EBSR_EV_RO_LO 6
`define EBSR_EV_RO_HI 9
`define EBSR_CFG_ERR_BIT 15
`define EBSR_CFG_RST_BIT 14
`define EBSR_CFG_SZ_HI 13
`define EBSR_CFG_SZ_LO 12
`define EBSR_CFG_BASE_HI 11
`define EBSR_CFG_BASE_LO 8
`define EBSR_CFG_RESET 16'h00ff
`define EBSR_CFG_RSVD_RD 8'hff
`define EBSR_PUSH_PEND_BIT 5
`endif

// ===== hdl/ebsr_pkg.sv
// types shared by the special register bank
package ebsr_pkg;
    // register access from the processor pipeline
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } ebsr_reg_req_t;
    // scheduler configuration as seen by the scheduling engine
    typedef struct packed {
        logic sched_reset;
        logic [1:0] section_size;
        logic [3:0] table_base;
        logic [15:0] section_entries;
        logic [3:0] max_sections;
    } ebsr_sched_cfg_t;
    typedef enum logic [0:0] {
        EBSR_LNK_IDLE = 1'b0,
        EBSR_LNK_WAIT = 1'b1
    } ebsr_lnk_state_t;
endpackage

// ===== hdl/ebsr_regs.sv
// event set/clear port, branch target registers and scheduler registers
//
// Operation
// (RULE1) event port write is a set/clear command
// (RULE2) command 0 clears indexed bit unless forced; code also keeps the bit set while ev_hw_set is high
// (RULE3) command 1 sets indexed bit unless forced
// (RULE4) firmware writes zeroes to reserved bits
// (RULE5) event bits 9:6 ignore set/clear commands
// (RULE6) bits 9:6 follow hardware; others port-only; code also lets ev_force_set, ev_force_clr and ev_hw_set change them
// (RULE7) linked load captures first halfword into shadow
// (RULE8) shadow branches take target from shadow
// (RULE9) targets are 12 bits; 15:12 read zero
// (RULE10) shadow branch stalls until halfword returns
// (RULE11) five instructions between load and branch avoid stall
// (RULE12) one instruction between shadow write and branch
// (RULE13) register branches jump to branch register
// (RULE14) one instruction between branch write and branch
// (RULE15) config bit 14 resets scheduler
// (RULE16) section size decodes entries and sections
// (RULE17) table base drives memory address 18:15
// (RULE18) config bits 7:0 reserved, undefined read
// (RULE19) firmware initializes config before scheduler use
// (RULE20) push completion loads offset from address 14:1
// (RULE21) push pending status clears on completion
// (RULE22) config bit 15 reports scheduler error
`timescale 1ns/10ps
`default_nettype none
`include "ebsr_params.svh"
module ebsr_regs
    import ebsr_pkg::*;
#(
    parameter int EV_WIDTH = 16,
    parameter int TGT_WIDTH = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register access
    input wire ebsr_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    // event sources
    input wire logic [3:0] ev_hw_status,
    input wire logic [EV_WIDTH-1:0] ev_force_set,
    input wire logic [EV_WIDTH-1:0] ev_force_clr,
    input wire logic [EV_WIDTH-1:0] ev_hw_set,
    output logic [EV_WIDTH-1:0] event_bits,
    // fast memory load return
    input wire logic fast_memory_load,
    input wire logic link_option,
    input wire logic fm_rdata_valid,
    input wire logic [15:0] fm_rdata,
    // branch issue
    input wire logic branch_via_shadow,
    input wire logic branch_via_shadow_link,
    input wire logic branch_via_register,
    input wire logic branch_via_register_link,
    output logic branch_take,
    output logic [TGT_WIDTH-1:0] branch_addr,
    output logic cpu_stall,
    // scheduling engine
    input wire logic sched_error,
    input wire logic schedule_push_done,
    input wire logic [18:0] fast_memory_address,
    input wire logic push_pending,
    output ebsr_sched_cfg_t sched_cfg,
    output logic [3:0] table_addr_hi,
    output logic push_pending_status
);
    if (EV_WIDTH != 16 || TGT_WIDTH != 12) begin : g_bad_param
        $error("ebsr_regs supports only 16 event bits and 12-bit targets");
    end

    logic [EV_WIDTH-1:0] ev_r;
    wire [EV_WIDTH-1:0] ev_nxt;
    logic [TGT_WIDTH-1:0] shadow_r;
    logic [TGT_WIDTH-1:0] shadow_nxt;
    logic [TGT_WIDTH-1:0] branch_r;
    logic [6:0] cfg_r;
    logic [13:0] sched_addr_r;
    logic err_r;
    ebsr_lnk_state_t lnk_r;
    ebsr_lnk_state_t lnk_nxt;

    wire wr_ev = reg_req.wr && reg_req.addr == `EBSR_OFS_EVENT_SC;
    wire wr_sh = reg_req.wr && reg_req.addr == `EBSR_OFS_SHADOW;
    wire wr_br = reg_req.wr && reg_req.addr == `EBSR_OFS_BRANCH;
    wire wr_cfg = reg_req.wr && reg_req.addr == `EBSR_OFS_SCHED_CFG;
    wire ev_cmd = reg_req.wdata[`EBSR_EV_CMD_BIT];
    wire [3:0] ev_idx = reg_req.wdata[`EBSR_EV_IDX_HI:0];
    wire lnk_start = fast_memory_load && link_option;
    wire any_bvs = branch_via_shadow || branch_via_shadow_link;
    wire any_bvr = branch_via_register || branch_via_register_link;
    // shadow capture of the returned halfword
    // (RULE7) capture first halfword
    wire capture = lnk_r == EBSR_LNK_WAIT && fm_rdata_valid;

    // event bits: one generate slice per bit
    genvar gi;
    generate
        for (gi = 0; gi < EV_WIDTH; gi++) begin : g_ev
            if (gi >= `EBSR_EV_RO_LO && gi <= `EBSR_EV_RO_HI) begin : g_ro
                // (RULE5) read-only status bits
                // (RULE6) follow hardware condition
                assign ev_nxt[gi] = ev_hw_status[gi-`EBSR_EV_RO_LO];
            end else begin : g_rw
                wire hit = wr_ev && ev_idx == 4'(gi);
                // (RULE1) command decode
                // (RULE2) clear unless forced set or hardware set
                // (RULE3) set unless forced clear
                assign ev_nxt[gi] = ev_force_set[gi] ? 1'b1 :
                                    ev_force_clr[gi] ? 1'b0 :
                                    ev_hw_set[gi] ? 1'b1 :
                                    hit ? ev_cmd : ev_r[gi];
            end
        end
    endgenerate

    assign shadow_nxt = capture ? fm_rdata[TGT_WIDTH-1:0] :
                        wr_sh ? reg_req.wdata[TGT_WIDTH-1:0] : shadow_r;

    always_comb begin
        lnk_nxt = lnk_r;
        case (lnk_r)
            EBSR_LNK_IDLE: begin
                if (lnk_start) begin
                    lnk_nxt = EBSR_LNK_WAIT;
                end
            end
            EBSR_LNK_WAIT: begin
                if (fm_rdata_valid) begin
                    lnk_nxt = EBSR_LNK_IDLE;
                end
            end
            default: lnk_nxt = EBSR_LNK_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ev_r <= '0;
            shadow_r <= '0;
            branch_r <= '0;
            lnk_r <= EBSR_LNK_IDLE;
        end else begin
            ev_r <= ev_nxt;
            shadow_r <= shadow_nxt;
            lnk_r <= lnk_nxt;
            if (wr_br) begin
                branch_r <= reg_req.wdata[TGT_WIDTH-1:0];
            end
        end
    end

    // scheduler configuration; reserved low byte is not stored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_r <= 7'(`EBSR_CFG_RESET >> 8);
            err_r <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_r <= reg_req.wdata[14:8];
            end
            // (RULE22) error set wins over write clear
            err_r <= sched_error || (wr_cfg ? reg_req.wdata[`EBSR_CFG_ERR_BIT] : err_r);
        end
    end

    // (RULE20) push completion captures offset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sched_addr_r <= '0;
        end else if (schedule_push_done) begin
            sched_addr_r <= fast_memory_address[14:1];
        end
    end

    // (RULE15) scheduler reset bit
    assign sched_cfg.sched_reset = cfg_r[`EBSR_CFG_RST_BIT-8];
    assign sched_cfg.section_size = cfg_r[`EBSR_CFG_SZ_HI-8:`EBSR_CFG_SZ_LO-8];
    assign sched_cfg.table_base = cfg_r[`EBSR_CFG_BASE_HI-8:0];
    // (RULE16) section size decode
    assign sched_cfg.section_entries = 16'h0800 << sched_cfg.section_size;
    assign sched_cfg.max_sections = 4'h8 >> sched_cfg.section_size;
    // (RULE17) table base drives address 18:15
    assign table_addr_hi = sched_cfg.table_base;
    // (RULE21) pending status from engine
    assign push_pending_status = push_pending;

    // branch target selection; a branch released by the returning
    // halfword must not jump to the stale shadow contents
    // (RULE8) shadow branch target
    // (RULE13) register branch target
    wire [TGT_WIDTH-1:0] shadow_fwd = capture ? fm_rdata[TGT_WIDTH-1:0] : shadow_r;
    assign branch_addr = any_bvs ? shadow_fwd : branch_r;
    // (RULE10) stall while linked halfword outstanding
    assign cpu_stall = any_bvs && lnk_r == EBSR_LNK_WAIT && !fm_rdata_valid;
    assign branch_take = (any_bvs && !cpu_stall) || any_bvr;
    assign event_bits = ev_r;

    // read mux
    // (RULE9) reserved target bits read zero
    // (RULE18) reserved config bits read as ones
    always_comb begin
        reg_rdata = 16'h0000;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `EBSR_OFS_EVENT_SC: reg_rdata = ev_r;
                `EBSR_OFS_SHADOW: reg_rdata = {4'h0, shadow_r};
                `EBSR_OFS_BRANCH: reg_rdata = {4'h0, branch_r};
                `EBSR_OFS_SCHED_CFG: reg_rdata = {err_r, cfg_r[6:0], `EBSR_CFG_RSVD_RD};
                `EBSR_OFS_SCHED_ADDR: reg_rdata = {2'h0, sched_addr_r};
                default: reg_rdata = 16'h0000;
            endcase
        end
    end

    // checks
    a_ev_set_cmd: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        wr_ev && ev_cmd && ev_idx == 4'h2 && !ev_force_clr[2] |=> ev_r[2])
        else $error("event set command lost");
    a_ev_clr_cmd: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
        wr_ev && !ev_cmd && ev_idx == 4'h2 && !ev_force_set[2] && !ev_hw_set[2] |=> !ev_r[2])
        else $error("event clear command lost");
    a_ev_ro_bits: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
        !rst |=> ev_r[9:6] == $past(ev_hw_status))
        else $error("read-only event bits not following hardware");
    a_ev_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
        !wr_ev && ev_force_set[0] == 1'b0 && !ev_force_clr[0] && !ev_hw_set[0] |=> $stable(ev_r[0]))
        else $error("event bit changed without command");
    a_shadow_cap: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
        capture |=> shadow_r == $past(fm_rdata[11:0]))
        else $error("shadow did not capture halfword");
    a_stall_end: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
        lnk_r == EBSR_LNK_WAIT && fm_rdata_valid |=> !cpu_stall)
        else $error("stall did not end on halfword");
    a_bvs_target: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
        branch_take && any_bvs && !capture |-> branch_addr == shadow_r)
        else $error("shadow branch used wrong target");
    a_bvr_target: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
        branch_take && !any_bvs |-> branch_addr == branch_r)
        else $error("register branch used wrong target");
    a_push_addr: assert property (@(posedge clk_sys) disable iff (rst) // RULE20
        schedule_push_done |=> sched_addr_r == $past(fast_memory_address[14:1]))
        else $error("scheduled address not captured");
    a_size_decode: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        sched_cfg.section_size == 2'h3 |-> sched_cfg.section_entries == 16'h4000)
        else $error("section size decode wrong");
    a_err_sticky: assert property (@(posedge clk_sys) disable iff (rst) // RULE22
        sched_error |=> err_r)
        else $error("scheduler error flag not set");

    // event port checks
    a_ev_one_bit: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
        wr_ev && ev_idx == 4'h1 && ev_force_set == '0 && ev_force_clr == '0 &&
        ev_hw_set == '0 |=> ev_r[15:10] == $past(ev_r[15:10]) &&
        ev_r[5:2] == $past(ev_r[5:2]) && ev_r[0] == $past(ev_r[0]))
        else $error("event write touched another bit");
    a_ev_ro_cmd: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
        wr_ev && ev_idx == 4'h7 |=> ev_r[7] == $past(ev_hw_status[1]))
        else $error("command changed a read-only event bit");

    // branch checks
    a_stall_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
        any_bvs && !any_bvr && lnk_r == EBSR_LNK_WAIT && !fm_rdata_valid |->
        cpu_stall && !branch_take)
        else $error("shadow branch not stalled");
    a_bvs_fwd: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
        any_bvs && capture |-> branch_take && branch_addr == fm_rdata[11:0])
        else $error("released branch missed returned halfword");
    a_lnk_wait: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
        lnk_start && lnk_r == EBSR_LNK_IDLE |=> lnk_r == EBSR_LNK_WAIT)
        else $error("linked load not tracked");
    a_tgt_rsvd: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
        reg_req.rd && (reg_req.addr == `EBSR_OFS_SHADOW || reg_req.addr == `EBSR_OFS_BRANCH)
        |-> reg_rdata[15:12] == 4'h0)
        else $error("reserved target bits not zero");

    // scheduler checks
    a_size_small: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        sched_cfg.section_size == 2'h0 |->
        sched_cfg.section_entries == 16'h0800 && sched_cfg.max_sections == 4'h8)
        else $error("smallest section size decode wrong");
    a_size_mid: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        sched_cfg.section_size == 2'h1 |->
        sched_cfg.section_entries == 16'h1000 && sched_cfg.max_sections == 4'h4)
        else $error("second section size decode wrong");
    a_size_two: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        sched_cfg.section_size == 2'h2 |->
        sched_cfg.section_entries == 16'h2000 && sched_cfg.max_sections == 4'h2)
        else $error("third section size decode wrong");
    a_base_drive: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
        wr_cfg |=> table_addr_hi == $past(reg_req.wdata[11:8]))
        else $error("table base not driven");
    a_cfg_rst_bit: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
        wr_cfg |=> sched_cfg.sched_reset == $past(reg_req.wdata[14]))
        else $error("scheduler reset bit not applied");
    a_cfg_rsvd_rd: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
        reg_req.rd && reg_req.addr == `EBSR_OFS_SCHED_CFG |-> reg_rdata[7:0] == 8'hff)
        else $error("reserved config bits changed");
    a_err_write: assert property (@(posedge clk_sys) disable iff (rst) // RULE22
        wr_cfg && !sched_error |=> err_r == $past(reg_req.wdata[15]))
        else $error("error flag write not stored");
    a_addr_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE20
        !schedule_push_done |=> $stable(sched_addr_r))
        else $error("scheduled address changed without push");
    // coverage of main scenarios
    c_bvs_fwd: cover property (@(posedge clk_sys) disable iff (rst) any_bvs && capture);
    c_err_set: cover property (@(posedge clk_sys) disable iff (rst) sched_error && wr_cfg);
    c_link_stall: cover property (@(posedge clk_sys) disable iff (rst) cpu_stall ##1 !cpu_stall);
    c_ev_set: cover property (@(posedge clk_sys) disable iff (rst) wr_ev && ev_cmd);
    c_push: cover property (@(posedge clk_sys) disable iff (rst) schedule_push_done);
endmodule
`default_nettype wire

// ===== bench/ebsr_regs_tb.sv
// self-checking bench for the special register bank
`timescale 1ns/10ps
`default_nettype none
module ebsr_regs_tb
    import ebsr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    ebsr_reg_req_t rq = '0;
    logic [3:0] hs = 4'ha, br = '0;
    logic [15:0] fs = '0, fc = '0, fd = '0, hw = '0, rdata, evb, v, ev_m, sh_m, bt_m;
    logic ld = 1'b0, lk = 1'b0, fv = 1'b0, se = 1'b0, pd = 1'b0, pp = 1'b0, take, stall, pps;
    logic [18:0] fa = '0;
    logic [11:0] baddr;
    logic [3:0] tah;
    ebsr_sched_cfg_t cfg;
    int error_cnt = 0, num_checks = 0, i;
    ebsr_regs u_dut (.clk_sys(clk_sys), .rst(rst), .reg_req(rq), .reg_rdata(rdata),
        .ev_hw_status(hs), .ev_force_set(fs), .ev_force_clr(fc), .ev_hw_set(hw),
        .event_bits(evb), .fast_memory_load(ld), .link_option(lk), .fm_rdata_valid(fv),
        .fm_rdata(fd), .branch_via_shadow(br[3]), .branch_via_shadow_link(br[2]),
        .branch_via_register(br[1]), .branch_via_register_link(br[0]), .branch_take(take),
        .branch_addr(baddr), .cpu_stall(stall), .sched_error(se), .schedule_push_done(pd),
        .fast_memory_address(fa), .push_pending(pp), .sched_cfg(cfg),
        .table_addr_hi(tah), .push_pending_status(pps));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        rq <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        rq <= '0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input string n);
        @(posedge clk_sys);
        rq <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_sys);
        chk(n, e, rdata);
        rq <= '0;
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        complete_run;
    end
    initial begin
        i = $urandom(28673);
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        rd(6'h3c, 16'h00ff, "cfg_reset");
        ev_m = {6'h00, hs, 6'h00};
        for (i = 0; i < 40; i++) begin
            v = 16'($urandom);
            v = {8'h00, v[7], 3'h0, v[3:0]};
            wr(6'h39, v);
            if (v[3:0] < 6 || v[3:0] > 9) ev_m[v[3:0]] = v[7];
            chk("event", ev_m, evb);
        end
        @(posedge clk_sys);
        hs <= 4'h5;
        ev_m[9:6] = 4'h5;
        @(posedge clk_sys);
        #1 chk("event_hw", ev_m, evb);
        @(posedge clk_sys);
        fc <= 16'h0008;
        wr(6'h39, 16'h0083);
        ev_m[3] = 1'b0;
        chk("event_fclr", ev_m, evb);
        @(posedge clk_sys);
        fc <= '0;
        fs <= 16'h0008;
        wr(6'h39, 16'h0003);
        ev_m[3] = 1'b1;
        chk("event_fset", ev_m, evb);
        @(posedge clk_sys);
        fs <= '0;
        rq <= '{1'b1, 1'b0, 6'h39, 16'h0004};
        hw <= 16'h0010;
        @(posedge clk_sys);
        rq <= '0;
        hw <= '0;
        ev_m[4] = 1'b1;
        #1 chk("event_hwset", ev_m, evb);
        wr(6'h39, 16'h0004);
        ev_m[4] = 1'b0;
        chk("event_hwclr", ev_m, evb);
        sh_m = 16'($urandom);
        bt_m = 16'($urandom);
        wr(6'h3a, sh_m);
        wr(6'h3b, bt_m);
        rd(6'h3a, {4'h0, sh_m[11:0]}, "shadow");
        rd(6'h3b, {4'h0, bt_m[11:0]}, "branch");
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            br <= 4'b1000 >> i;
            #1 chk("take", 2'b10, {take, stall});
            chk("addr", (i < 2) ? sh_m[11:0] : bt_m[11:0], baddr);
        end
        @(posedge clk_sys);
        br <= 0;
        ld <= 1;
        lk <= 1;
        @(posedge clk_sys);
        ld <= 0;
        lk <= 0;
        br <= 4'b0100;
        repeat (3) begin
            #1 chk("stall", 2'b01, {take, stall});
            @(posedge clk_sys);
        end
        fd <= 16'($urandom);
        fv <= 1;
        #1 chk("release", 2'b10, {take, stall});
        chk("release_addr", fd[11:0], baddr);
        @(posedge clk_sys);
        fv <= 0;
        br <= 0;
        rd(6'h3a, {4'h0, fd[11:0]}, "capture");
        @(posedge clk_sys);
        ld <= 1'b1;
        lk <= 1'b1;
        @(posedge clk_sys);
        ld <= 1'b0;
        lk <= 1'b0;
        fd <= 16'($urandom);
        fv <= 1'b1;
        @(posedge clk_sys);
        fv <= 1'b0;
        repeat (4) @(posedge clk_sys);
        br <= 4'b1000;
        #1 chk("no_stall", 2'b10, {take, stall});
        chk("fresh_addr", fd[11:0], baddr);
        @(posedge clk_sys);
        br <= '0;
        for (i = 0; i < 4; i++) begin
            v = 16'($urandom);
            v = {1'b0, v[14], i[1:0], v[11:8], 8'h00};
            wr(6'h3c, v);
            chk("entries", 32'd2048 << i, cfg.section_entries);
            chk("sections", 32'd8 >> i, cfg.max_sections);
            chk("base", v[11:8], tah);
            chk("sreset", v[14], cfg.sched_reset);
            rd(6'h3c, {v[15:8], 8'hff}, "cfg");
        end
        @(posedge clk_sys);
        se <= 1;
        @(posedge clk_sys);
        se <= 0;
        rd(6'h3c, {1'b1, v[14:8], 8'hff}, "cfg_err");
        @(posedge clk_sys);
        rq <= '{1'b1, 1'b0, 6'h3c, {1'b0, v[14:0]}};
        se <= 1'b1;
        @(posedge clk_sys);
        rq <= '0;
        se <= 1'b0;
        rd(6'h3c, {1'b1, v[14:8], 8'hff}, "cfg_err_win");
        wr(6'h3c, {1'b0, v[14:0]});
        rd(6'h3c, {1'b0, v[14:8], 8'hff}, "cfg_err_clr");
        @(posedge clk_sys);
        pp <= 1;
        fa <= 19'($urandom);
        #1 chk("pending", 1, pps);
        @(posedge clk_sys);
        pd <= 1;
        pp <= 0;
        @(posedge clk_sys);
        pd <= 0;
        #1 chk("pending", 0, pps);
        wr(6'h3d, 16'hffff);
        @(posedge clk_sys);
        rq <= '{1'b0, 1'b1, 6'h3d, 16'h0000};
        @(posedge clk_sys);
        chk("sched_addr", fa[14:1], rdata[13:0]);
        rq <= '0;
        rd(6'h00, 16'h0000, "unmapped");
        complete_run;
    end
endmodule
`default_nettype wire
